// >>> logic/mie_defs.svh
`ifndef MIE_DEFS_SVH
`define MIE_DEFS_SVH

`define MIE_OFS_INSTR   8'h00
`define MIE_OFS_ACC     8'h04
`define MIE_OFS_STATUS  8'h08
`define MIE_OFS_PC      8'h0C
`define MIE_OFS_WDT     8'h10
`define MIE_OFS_MADDR   8'h14
`define MIE_OFS_MDATA   8'h18
`define MIE_OFS_STACK   8'h1C
`define MIE_OFS_WAKE    8'h20

`define MIE_F_OP_HI     28
`define MIE_F_OP_LO     24
`define MIE_F_MADDR_HI  21
`define MIE_F_MADDR_LO  16
`define MIE_F_JADDR_HI  10
`define MIE_F_IMM_HI    7

`define MIE_ST_C        0
`define MIE_ST_AC       1
`define MIE_ST_Z        2
`define MIE_ST_OV       3
`define MIE_ST_PDF      4
`define MIE_ST_TO       5
`define MIE_ST_EMI      6
`define MIE_ST_BUSY     8
`define MIE_ST_HALT     9
`define MIE_ST_PC1      10
`define MIE_ST_PC2      11

`define MIE_WDT_CLEAR   8'h00
`define MIE_WDT_MAX     8'hFF
`define MIE_BCD_MAX     5'h09
`define MIE_BCD_ADJ     5'h06
`define MIE_ZERO32      32'h0000_0000

`endif

// >>> logic/mie_pkg.sv
package mie_pkg;
	typedef enum logic [4:0] {
		OP_NOP, OP_PRECLR1, OP_PRECLR2, OP_WDTCLR, OP_INV, OP_INVA, OP_DAA,
		OP_DEC, OP_DECREMENT_TO_ACCUMULATOR, OP_INC, OP_INCREMENT_TO_ACCUMULATOR, OP_HALT, OP_JMP, OP_MOVAI, OP_MOVAM,
		OP_MOVMA, OP_ORAM, OP_ORAI, OP_ORM, OP_RET, OP_RETA, OP_INTERRUPT_RETURN, OP_RL, OP_RLA
	} mie_op_t;

	typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_WAIT, ST_HALTED} mie_state_t;
endpackage

// >>> logic/mie_alu_if.sv
`timescale 1ns/1ps
interface mie_alu_if import mie_pkg::*; ();
	mie_op_t    op;
	logic [7:0] acc;
	logic [7:0] mem;
	logic [7:0] imm;
	logic       c;
	logic       ac;
	logic [7:0] res;
	logic       c_out;
	logic       wr_acc;
	logic       wr_mem;
	logic       upd_z;
	logic       upd_c;

	modport alu (input op, acc, mem, imm, c, ac,
		output res, c_out, wr_acc, wr_mem, upd_z, upd_c);
	modport core (output op, acc, mem, imm, c, ac,
		input res, c_out, wr_acc, wr_mem, upd_z, upd_c);
endinterface

// >>> logic/mie_alu.sv
`timescale 1ns/1ps
`include "mie_defs.svh"
module mie_alu import mie_pkg::*; (
	mie_alu_if.alu bus
);
	logic       lo_adj;
	logic [4:0] lo_sum;
	logic       nib_carry;
	logic [4:0] hi_sum;
	logic       hi_adj;
	logic [4:0] hi_res;

	// Decimal adjust; the nibble carry comes from the low-nibble sum
	assign lo_adj    = ({1'b0, bus.acc[3:0]} > `MIE_BCD_MAX) | bus.ac;
	assign lo_sum    = {1'b0, bus.acc[3:0]} + (lo_adj ? `MIE_BCD_ADJ : 5'h00);
	assign nib_carry = lo_sum[4];
	assign hi_sum    = {1'b0, bus.acc[7:4]} + {4'h0, nib_carry};
	assign hi_adj    = (hi_sum > `MIE_BCD_MAX) | bus.c;
	assign hi_res    = hi_sum + (hi_adj ? `MIE_BCD_ADJ : 5'h00);

	always_comb begin
		bus.res    = 8'h00;
		bus.c_out  = bus.c;
		bus.wr_acc = 1'b0;
		bus.wr_mem = 1'b0;
		bus.upd_z  = 1'b0;
		bus.upd_c  = 1'b0;
		unique case (bus.op)
			OP_INV: begin
				bus.res = ~bus.mem;
				bus.wr_mem = 1'b1;
				bus.upd_z  = 1'b1;
			end
			OP_INVA: begin
				bus.res = ~bus.mem;
				bus.wr_acc = 1'b1;
				bus.upd_z  = 1'b1;
			end
			OP_DAA: begin
				bus.res    = {hi_res[3:0], lo_sum[3:0]};
				bus.wr_mem = 1'b1;
				bus.upd_c  = 1'b1;
				bus.c_out  = hi_adj ? 1'b1 : bus.c;
			end
			OP_DEC, OP_DECREMENT_TO_ACCUMULATOR: begin
				bus.res    = bus.mem - 8'h01;
				bus.wr_mem = (bus.op == OP_DEC);
				bus.wr_acc = (bus.op == OP_DECREMENT_TO_ACCUMULATOR);
				bus.upd_z  = 1'b1;
			end
			OP_INC, OP_INCREMENT_TO_ACCUMULATOR: begin
				bus.res    = bus.mem + 8'h01;
				bus.wr_mem = (bus.op == OP_INC);
				bus.wr_acc = (bus.op == OP_INCREMENT_TO_ACCUMULATOR);
				bus.upd_z  = 1'b1;
			end
			OP_MOVAI, OP_RETA: begin
				bus.res    = bus.imm;
				bus.wr_acc = 1'b1;
			end
			OP_MOVAM: begin
				bus.res    = bus.mem;
				bus.wr_acc = 1'b1;
			end
			OP_MOVMA: begin
				bus.res    = bus.acc;
				bus.wr_mem = 1'b1;
			end
			OP_ORAM, OP_ORM: begin
				bus.res    = bus.acc | bus.mem;
				bus.wr_acc = (bus.op == OP_ORAM);
				bus.wr_mem = (bus.op == OP_ORM);
				bus.upd_z  = 1'b1;
			end
			OP_ORAI: begin
				bus.res    = bus.acc | bus.imm;
				bus.wr_acc = 1'b1;
				bus.upd_z  = 1'b1;
			end
			OP_RL, OP_RLA: begin
				bus.res    = {bus.mem[6:0], bus.mem[7]};
				bus.wr_mem = (bus.op == OP_RL);
				bus.wr_acc = (bus.op == OP_RLA);
			end
			default: begin
				bus.res = 8'h00;
			end
		endcase
	end
endmodule

// >>> logic/mie_top.sv
`timescale 1ns/1ps
`include "mie_defs.svh"
module mie_top import mie_pkg::*; #(
	parameter int MEM_DEPTH   = 64,
	parameter int STACK_DEPTH = 6,
	parameter int WDT_PRESC   = 256
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             sys_clk_en
);
	localparam int AW  = $clog2(MEM_DEPTH);
	localparam int SPW = $clog2(STACK_DEPTH + 1);
	localparam int PW  = $clog2(WDT_PRESC);

	mie_state_t  state_q;
	mie_state_t  state_d;
	logic [31:0] instr_q;
	logic [7:0]  acc_q;
	logic [7:0]  mem_q [MEM_DEPTH];
	logic [AW-1:0] maddr_q;
	logic [10:0] pc_q;
	logic [10:0] stk_q [STACK_DEPTH];
	logic [SPW-1:0] sp_q;
	logic [7:0]  wdt_q;
	logic [PW-1:0] presc_q;
	logic        c_q;
	logic        ac_q;
	logic        z_q;
	logic        ov_q;
	logic        pdf_q;
	logic        to_q;
	logic        emi_q;
	logic        pc1_q;
	logic        pc2_q;
	logic [31:0] prdata_q;
	logic        pready_q;
	logic        pslverr_q;
	logic        clk_en_q;

	mie_alu_if alu_bus ();

	mie_alu u_alu (
		.bus (alu_bus)
	);

	// Bus decode
	wire setup    = psel & ~penable;
	wire access   = psel & penable & pready_q;
	wire bus_wr   = access & pwrite;
	wire hit_ins  = (paddr == `MIE_OFS_INSTR);
	wire hit_acc  = (paddr == `MIE_OFS_ACC);
	wire hit_st   = (paddr == `MIE_OFS_STATUS);
	wire hit_pc   = (paddr == `MIE_OFS_PC);
	wire hit_wdt  = (paddr == `MIE_OFS_WDT);
	wire hit_ma   = (paddr == `MIE_OFS_MADDR);
	wire hit_md   = (paddr == `MIE_OFS_MDATA);
	wire hit_stk  = (paddr == `MIE_OFS_STACK);
	wire hit_wake = (paddr == `MIE_OFS_WAKE);
	wire mapped   = hit_ins | hit_acc | hit_st | hit_pc | hit_wdt | hit_ma | hit_md
		| hit_stk | hit_wake;

	// Execution decode
	wire        exec      = (state_q == ST_EXEC);
	wire        idle      = (state_q == ST_IDLE);
	wire        halted    = (state_q == ST_HALTED);
	wire        busy      = ~idle;
	wire        ins_load  = bus_wr & hit_ins & idle;
	mie_op_t    op;
	assign op = mie_op_t'(instr_q[`MIE_F_OP_HI:`MIE_F_OP_LO]);
	wire [AW-1:0] m_addr  = instr_q[`MIE_F_MADDR_LO +: AW];
	wire [10:0] j_addr    = instr_q[`MIE_F_JADDR_HI:0];
	wire [7:0]  imm       = instr_q[`MIE_F_IMM_HI:0];
	wire        is_ret    = (op == OP_RET) | (op == OP_RETA) | (op == OP_INTERRUPT_RETURN);
	wire        do_pre1   = exec & (op == OP_PRECLR1);
	wire        do_pre2   = exec & (op == OP_PRECLR2);
	wire        pair_done = (do_pre1 & pc2_q) | (do_pre2 & pc1_q);
	wire        do_wdtclr = pair_done | (exec & (op == OP_WDTCLR));
	wire        do_halt   = exec & (op == OP_HALT);
	wire        wdt_tick  = (presc_q == PW'(WDT_PRESC - 1));
	wire        wdt_ovf   = wdt_tick & (wdt_q == `MIE_WDT_MAX);
	wire        wake      = (bus_wr & hit_wake & pwdata[0]) | wdt_ovf;
	wire [SPW-1:0] pop_idx = (sp_q == '0) ? '0 : sp_q - SPW'(1);
	wire        stk_full  = (sp_q == SPW'(STACK_DEPTH));
	wire [7:0]  mem_rd    = mem_q[m_addr];
	wire        z_new     = (alu_bus.res == 8'h00);

	assign alu_bus.op  = exec ? op : OP_NOP;
	assign alu_bus.acc = acc_q;
	assign alu_bus.mem = mem_rd;
	assign alu_bus.imm = imm;
	assign alu_bus.c   = c_q;
	assign alu_bus.ac  = ac_q;

	wire [31:0] st_word = {20'h0_0000, pc2_q, pc1_q, halted, busy, 1'b0, emi_q, to_q,
		pdf_q, ov_q, z_q, ac_q, c_q};
	wire [31:0] rd_mux =
		hit_ins  ? instr_q :
		hit_acc  ? {24'h00_0000, acc_q} :
		hit_st   ? st_word :
		hit_pc   ? {21'h00_0000, pc_q} :
		hit_wdt  ? {24'h00_0000, wdt_q} :
		hit_ma   ? {{(32 - AW){1'b0}}, maddr_q} :
		hit_md   ? {24'h00_0000, mem_q[maddr_q]} :
		hit_stk  ? {{(32 - SPW){1'b0}}, sp_q} : `MIE_ZERO32;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE:    if (ins_load) state_d = ST_EXEC;
			ST_EXEC: begin
				if (do_halt)
					state_d = ST_HALTED;
				else if (is_ret)
					state_d = ST_WAIT;
				else
					state_d = ST_IDLE;
			end
			ST_WAIT:    state_d = ST_IDLE;
			ST_HALTED:  if (wake) state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q  <= ST_IDLE;
			clk_en_q <= 1'b1;
		end else begin
			state_q  <= state_d;
			clk_en_q <= (state_d != ST_HALTED);
		end
	end

	// Registered answer: pready rises in the first access cycle, no extra wait
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= `MIE_ZERO32;
		end else begin
			pready_q  <= setup;
			pslverr_q <= setup & ~mapped;
			if (setup)
				prdata_q <= rd_mux;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			instr_q <= `MIE_ZERO32;
			maddr_q <= '0;
		end else begin
			if (ins_load)
				instr_q <= pwdata;
			if (bus_wr & hit_ma)
				maddr_q <= pwdata[AW-1:0];
		end
	end

	// Execution wins over a bus write in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			acc_q <= 8'h00;
		else if (exec & alu_bus.wr_acc)
			acc_q <= alu_bus.res;
		else if (bus_wr & hit_acc)
			acc_q <= pwdata[7:0];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < MEM_DEPTH; i++)
				mem_q[i] <= 8'h00;
		end else if (exec & alu_bus.wr_mem) begin
			mem_q[m_addr] <= alu_bus.res;
		end else if (bus_wr & hit_md) begin
			mem_q[maddr_q] <= pwdata[7:0];
		end
	end

	// Only the flag an operation names moves; the rest hold
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			c_q   <= 1'b0;
			ac_q  <= 1'b0;
			z_q   <= 1'b0;
			ov_q  <= 1'b0;
			emi_q <= 1'b0;
		end else if (exec) begin
			if (alu_bus.upd_z)
				z_q <= z_new;
			if (alu_bus.upd_c)
				c_q <= alu_bus.c_out;
			if (op == OP_INTERRUPT_RETURN)
				emi_q <= 1'b1;
		end else if (bus_wr & hit_st) begin
			c_q   <= pwdata[`MIE_ST_C];
			ac_q  <= pwdata[`MIE_ST_AC];
			z_q   <= pwdata[`MIE_ST_Z];
			ov_q  <= pwdata[`MIE_ST_OV];
			emi_q <= pwdata[`MIE_ST_EMI];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_q <= 11'h000;
			sp_q <= '0;
			for (int i = 0; i < STACK_DEPTH; i++)
				stk_q[i] <= 11'h000;
		end else if (exec) begin
			if (op == OP_JMP)
				pc_q <= j_addr;
			else if (is_ret) begin
				pc_q <= stk_q[pop_idx];
				sp_q <= pop_idx;
			end else
				pc_q <= pc_q + 11'h001;
		end else if (bus_wr & hit_stk & ~stk_full) begin
			stk_q[sp_q] <= pwdata[10:0];
			sp_q        <= sp_q + SPW'(1);
		end
	end

	// Watchdog; a time-out set wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wdt_q   <= `MIE_WDT_CLEAR;
			presc_q <= '0;
			to_q    <= 1'b0;
			pdf_q   <= 1'b0;
			pc1_q   <= 1'b0;
			pc2_q   <= 1'b0;
		end else begin
			if (do_halt) begin
				wdt_q   <= `MIE_WDT_CLEAR;
				presc_q <= '0;
				pdf_q   <= 1'b1;
			end else if (do_wdtclr) begin
				wdt_q <= `MIE_WDT_CLEAR;
				pdf_q <= 1'b0;
				presc_q <= wdt_tick ? '0 : presc_q + PW'(1);
			end else begin
				presc_q <= wdt_tick ? '0 : presc_q + PW'(1);
				if (wdt_tick)
					wdt_q <= wdt_q + 8'h01;
			end
			if (wdt_ovf)
				to_q <= 1'b1;
			else if (do_halt | do_wdtclr)
				to_q <= 1'b0;
			if (pair_done) begin
				pc1_q <= 1'b0;
				pc2_q <= 1'b0;
			end else if (do_pre1)
				pc1_q <= 1'b1;
			else if (do_pre2)
				pc2_q <= 1'b1;
		end
	end

	assign prdata     = prdata_q;
	assign pready     = pready_q;
	assign pslverr    = pslverr_q;
	assign sys_clk_en = clk_en_q;

	property p_pair_clear;
		@(posedge pclk) disable iff (!presetn)
		pair_done |=> (wdt_q == `MIE_WDT_CLEAR) && !pdf_q && (to_q == $past(wdt_ovf))
			&& !pc1_q && !pc2_q;
	endproperty
	a_pair_clear: assert property (p_pair_clear) else $error("pre-clear pair failed");

	property p_single_pre;
		@(posedge pclk) disable iff (!presetn)
		(do_pre1 && !pc2_q && !wdt_ovf) |=> pc1_q && (to_q == $past(to_q))
			&& (pdf_q == $past(pdf_q));
	endproperty
	a_single_pre: assert property (p_single_pre) else $error("single pre-clear moved flags");

	property p_invert;
		@(posedge pclk) disable iff (!presetn)
		(exec && op == OP_INV) |=> (mem_q[$past(m_addr)] == ~$past(mem_rd))
			&& (z_q == ($past(mem_rd) == 8'hFF)) && (c_q == $past(c_q));
	endproperty
	a_invert: assert property (p_invert) else $error("invert result wrong");

	property p_daa_acc;
		@(posedge pclk) disable iff (!presetn)
		(exec && op == OP_DAA) |=> (acc_q == $past(acc_q)) && (z_q == $past(z_q));
	endproperty
	a_daa_acc: assert property (p_daa_acc) else $error("decimal adjust touched acc");

	property p_halt;
		@(posedge pclk) disable iff (!presetn)
		do_halt |=> pdf_q && (to_q == $past(wdt_ovf)) && (wdt_q == `MIE_WDT_CLEAR) && !sys_clk_en
			&& (pc_q == $past(pc_q) + 11'h001);
	endproperty
	a_halt: assert property (p_halt) else $error("power-down entry wrong");

	property p_jump;
		@(posedge pclk) disable iff (!presetn)
		(exec && op == OP_JMP) |=> (pc_q == $past(j_addr)) && $stable(z_q) && $stable(c_q);
	endproperty
	a_jump: assert property (p_jump) else $error("jump target wrong");

	property p_ret_two;
		@(posedge pclk) disable iff (!presetn)
		(exec && op == OP_RET) |=> (state_q == ST_WAIT) ##1 (state_q == ST_IDLE);
	endproperty
	a_ret_two: assert property (p_ret_two) else $error("return not two cycles");

	property p_interrupt_return;
		@(posedge pclk) disable iff (!presetn)
		(exec && op == OP_INTERRUPT_RETURN) |=> emi_q && (pc_q == $past(stk_q[pop_idx]));
	endproperty
	a_interrupt_return: assert property (p_interrupt_return) else $error("interrupt return wrong");

	property p_rotate;
		@(posedge pclk) disable iff (!presetn)
		(exec && op == OP_RLA) |=> (acc_q == {$past(mem_rd[6:0]), $past(mem_rd[7])})
			&& $stable(z_q) && $stable(c_q);
	endproperty
	a_rotate: assert property (p_rotate) else $error("rotate left wrong");

	property p_apb_ready;
		@(posedge pclk) disable iff (!presetn)
		(psel && !penable) |=> pready ##1 !pready;
	endproperty
	a_apb_ready: assert property (p_apb_ready) else $error("pready timing wrong");
endmodule

// >>> testbench/mie_tb_imem.sv
`timescale 1ns/1ps
module mie_tb_imem import mie_pkg::*; (
	input  wire mie_op_t     op,
	input  wire logic [5:0]  ma,
	input  wire logic [10:0] fld,
	output logic      [31:0] word
);
	// Jump target and immediate overlap in the low bits, as the fetch path expects
	assign word = {3'h0, op, 2'h0, ma, 5'h00, fld};
endmodule

// >>> testbench/test_mcu_instruction_execute_subset.sv
`timescale 1ns/1ps
`include "mie_defs.svh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_errors++; \
	$display("ERROR %0t: got %h exp %h", $time, a, e); end end
module test_mcu_instruction_execute_subset import mie_pkg::*; ;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        sys_clk_en;
	mie_op_t     im_op;
	logic [5:0]  im_ma;
	logic [10:0] im_f;
	logic [31:0] im_word;
	logic [31:0] rd;
	logic        err;
	int          n_errors;
	int          n_compared;

	mie_top #(.WDT_PRESC(64)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .sys_clk_en(sys_clk_en));
	mie_tb_imem i_imem (.op(im_op), .ma(im_ma), .fld(im_f), .word(im_word));

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) `CHK(1'b0, 1'b1)
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic run(input mie_op_t op, input logic [5:0] ma, input logic [10:0] f);
		int k;
		im_op = op;
		im_ma = ma;
		im_f = f;
		#1;
		apb(1'b1, `MIE_OFS_INSTR, im_word);
		k = 0;
		do begin
			apb(1'b0, `MIE_OFS_STATUS, 32'h0);
			k++;
		end while (rd[`MIE_ST_BUSY] !== 1'b0 && k < 8);
	endtask

	task automatic setm(input logic [5:0] a, input logic [7:0] d);
		apb(1'b1, `MIE_OFS_MADDR, {26'h0, a});
		apb(1'b1, `MIE_OFS_MDATA, {24'h0, d});
	endtask

	task automatic chkm(input logic [5:0] a, input logic [7:0] e);
		apb(1'b1, `MIE_OFS_MADDR, {26'h0, a});
		apb(1'b0, `MIE_OFS_MDATA, 32'h0);
		`CHK(rd, {24'h0, e})
	endtask

	task automatic chkr(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(rd, e)
	endtask

	task automatic chks(input logic [3:0] e);
		apb(1'b0, `MIE_OFS_STATUS, 32'h0);
		`CHK(rd[3:0], e)
	endtask

	task automatic t_inv();
		apb(1'b1, `MIE_OFS_STATUS, 32'h0000_000B);
		setm(6'h05, 8'hFF);
		run(OP_INV, 6'h05, 11'h000);
		chkm(6'h05, 8'h00);
		chks(4'hF);
		setm(6'h05, 8'h0F);
		run(OP_INVA, 6'h05, 11'h000);
		chkr(`MIE_OFS_ACC, 32'h0000_00F0);
		chkm(6'h05, 8'h0F);
		chks(4'hB);
	endtask

	task automatic t_incdec();
		apb(1'b1, `MIE_OFS_STATUS, 32'h0);
		setm(6'h07, 8'hFF);
		run(OP_INC, 6'h07, 11'h000);
		chkm(6'h07, 8'h00);
		chks(4'h4);
		run(OP_DECREMENT_TO_ACCUMULATOR, 6'h07, 11'h000);
		chkr(`MIE_OFS_ACC, 32'h0000_00FF);
		chkm(6'h07, 8'h00);
		chks(4'h0);
		setm(6'h07, 8'h01);
		run(OP_DEC, 6'h07, 11'h000);
		chkm(6'h07, 8'h00);
		chks(4'h4);
		run(OP_INCREMENT_TO_ACCUMULATOR, 6'h07, 11'h000);
		chkr(`MIE_OFS_ACC, 32'h0000_0001);
		chks(4'h0);
	endtask

	task automatic t_daa();
		logic [7:0] acc[4] = '{8'h9A, 8'h15, 8'h45, 8'h23};
		logic [1:0] st[4] = '{2'h0, 2'h2, 2'h1, 2'h0};
		logic [7:0] em[4] = '{8'h00, 8'h1B, 8'hA5, 8'h23};
		logic       ec[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, `MIE_OFS_ACC, {24'h0, acc[i]});
			apb(1'b1, `MIE_OFS_STATUS, {30'h0, st[i]});
			setm(6'h09, 8'h77);
			run(OP_DAA, 6'h09, 11'h000);
			chkm(6'h09, em[i]);
			chkr(`MIE_OFS_ACC, {24'h0, acc[i]});
			chks({2'b00, st[i][1], ec[i]});
		end
	endtask

	task automatic t_move_or();
		apb(1'b1, `MIE_OFS_STATUS, 32'h0000_000F);
		run(OP_MOVAI, 6'h00, 11'h05A);
		chkr(`MIE_OFS_ACC, 32'h0000_005A);
		run(OP_MOVMA, 6'h03, 11'h000);
		chkm(6'h03, 8'h5A);
		setm(6'h04, 8'h81);
		run(OP_MOVAM, 6'h04, 11'h000);
		chkr(`MIE_OFS_ACC, 32'h0000_0081);
		chks(4'hF);
		apb(1'b1, `MIE_OFS_STATUS, 32'h0);
		run(OP_MOVAI, 6'h00, 11'h000);
		setm(6'h04, 8'h00);
		run(OP_ORAM, 6'h04, 11'h000);
		chks(4'h4);
		run(OP_MOVAI, 6'h00, 11'h030);
		setm(6'h04, 8'h05);
		run(OP_ORM, 6'h04, 11'h000);
		chkm(6'h04, 8'h35);
		chkr(`MIE_OFS_ACC, 32'h0000_0030);
		chks(4'h0);
		run(OP_ORAI, 6'h00, 11'h00C);
		run(OP_ORAM, 6'h04, 11'h000);
		chkr(`MIE_OFS_ACC, 32'h0000_003D);
	endtask

	task automatic t_rot_flow();
		apb(1'b1, `MIE_OFS_STATUS, 32'h0000_000F);
		setm(6'h02, 8'h81);
		run(OP_RL, 6'h02, 11'h000);
		chkm(6'h02, 8'h03);
		run(OP_RLA, 6'h02, 11'h000);
		chkr(`MIE_OFS_ACC, 32'h0000_0006);
		chkm(6'h02, 8'h03);
		run(OP_JMP, 6'h00, 11'h7A5);
		chkr(`MIE_OFS_PC, 32'h0000_07A5);
		run(OP_NOP, 6'h00, 11'h000);
		chkr(`MIE_OFS_PC, 32'h0000_07A6);
		chkr(`MIE_OFS_ACC, 32'h0000_0006);
		chks(4'hF);
		apb(1'b1, `MIE_OFS_STACK, 32'h0000_0123);
		apb(1'b1, `MIE_OFS_STACK, 32'h0000_0045);
		apb(1'b1, `MIE_OFS_STACK, 32'h0000_0300);
		run(OP_RET, 6'h00, 11'h000);
		chkr(`MIE_OFS_PC, 32'h0000_0300);
		apb(1'b1, `MIE_OFS_STATUS, 32'h0);
		run(OP_RETA, 6'h00, 11'h03C);
		chkr(`MIE_OFS_PC, 32'h0000_0045);
		chkr(`MIE_OFS_ACC, 32'h0000_003C);
		run(OP_INTERRUPT_RETURN, 6'h00, 11'h000);
		chkr(`MIE_OFS_PC, 32'h0000_0123);
		apb(1'b0, `MIE_OFS_STATUS, 32'h0);
		`CHK(rd[`MIE_ST_EMI], 1'b1)
		chkr(`MIE_OFS_STACK, 32'h0);
		chkr(8'h24, 32'h0);
		`CHK(err, 1'b1)
	endtask

	task automatic t_wdt();
		run(OP_HALT, 6'h00, 11'h000);
		`CHK(sys_clk_en, 1'b0)
		chkr(`MIE_OFS_PC, 32'h0000_0124);
		apb(1'b0, `MIE_OFS_STATUS, 32'h0);
		`CHK(rd[`MIE_ST_TO:`MIE_ST_PDF], 2'b01)
		apb(1'b0, `MIE_OFS_WDT, 32'h0);
		`CHK(rd < 2, 1'b1)
		run(OP_JMP, 6'h00, 11'h000);
		chkr(`MIE_OFS_PC, 32'h0000_0124);
		chkm(6'h03, 8'h5A);
		apb(1'b1, `MIE_OFS_WAKE, 32'h1);
		// The enable is launched by the access edge itself; look one edge later
		@(posedge pclk);
		`CHK(sys_clk_en, 1'b1)
		// Let the count climb so that a missing clear shows up
		repeat (300) @(posedge pclk);
		run(OP_PRECLR1, 6'h00, 11'h000);
		`CHK(rd[`MIE_ST_PC1], 1'b1)
		`CHK(rd[`MIE_ST_PDF], 1'b1)
		apb(1'b0, `MIE_OFS_WDT, 32'h0);
		`CHK(rd > 1, 1'b1)
		run(OP_PRECLR2, 6'h00, 11'h000);
		`CHK(rd[`MIE_ST_TO:`MIE_ST_PDF], 2'b00)
		apb(1'b0, `MIE_OFS_WDT, 32'h0);
		`CHK(rd < 2, 1'b1)
		run(OP_HALT, 6'h00, 11'h000);
		apb(1'b1, `MIE_OFS_WAKE, 32'h1);
		repeat (300) @(posedge pclk);
		run(OP_WDTCLR, 6'h00, 11'h000);
		`CHK(rd[`MIE_ST_TO:`MIE_ST_PDF], 2'b00)
		apb(1'b0, `MIE_OFS_WDT, 32'h0);
		`CHK(rd < 2, 1'b1)
	endtask

	task automatic test_done();
		$display("Mismatches %0d of %0d comparisons", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	initial begin
		#2_000_000;
		n_errors++;
		test_done();
	end

	initial begin
		n_errors = 0;
		n_compared = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		im_op = OP_NOP;
		im_ma = 6'h00;
		im_f = 11'h000;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_inv();
		t_incdec();
		t_daa();
		t_move_or();
		t_rot_flow();
		t_wdt();
		test_done();
	end
endmodule
